// ### src/amsu_pkg.sv
// Package: register map, field layouts, reset values and timing for the axis motion status unit
package amsu_pkg;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CONTROL       = 8'h00;
	localparam logic [7:0] OFF_JOG_SELECT    = 8'h04;
	localparam logic [7:0] OFF_SLOW_JOG      = 8'h08;
	localparam logic [7:0] OFF_AXIS_SPEED    = 8'h0C;
	localparam logic [7:0] OFF_MOVE_CMD      = 8'h10;
	localparam logic [7:0] OFF_MOVE_STATUS   = 8'h14;
	localparam logic [7:0] OFF_OFFSET        = 8'h18;
	localparam logic [7:0] OFF_MEAS_POS      = 8'h1C;
	localparam logic [7:0] OFF_MEAS_SPEED    = 8'h20;
	localparam logic [7:0] OFF_REG_POS       = 8'h24;
	localparam logic [7:0] OFF_Z_POS         = 8'h28;
	localparam logic [7:0] OFF_WINDOW_OPEN   = 8'h2C;
	localparam logic [7:0] OFF_OUT_CLAMP     = 8'h30;
	localparam logic [7:0] OFF_DAC_CMD       = 8'h34;
	localparam logic [7:0] OFF_RUN_STATUS    = 8'h38;
	localparam logic [7:0] OFF_SERVO_PERIOD  = 8'h3C;
	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTL_MERGE   = 0;
	localparam int CTL_FINE    = 1;
	localparam int CTL_SERVO   = 2;
	localparam int CTL_WINDOW  = 3;
	localparam int CTL_ARM     = 4;
	localparam int CTL_CANCEL  = 5;
	localparam int CTL_RESOLV  = 6;
	localparam int CTL_SWRST   = 7;
	// Jog select fields: forward [5:0], reverse [13:8], fast [21:16]; -1 means none
	localparam int JSEL_FWD  = 0;
	localparam int JSEL_REV  = 8;
	localparam int JSEL_FAST = 16;
	localparam logic [5:0] JSEL_NONE = 6'h3F;
	// Move command fields: type [4:0], group [12:8], base [16], linked axis [23:20]
	localparam int MCMD_GROUP = 8;
	localparam int MCMD_BASE  = 16;
	localparam int MCMD_LINK  = 20;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_JOG_SELECT = 32'h003F3F3F;
	localparam logic [15:0] RST_OUT_CLAMP  = 16'h7FFF;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ          = 100;
	localparam int SERVO_PERIOD_US  = 1000;
	localparam int SERVO_CYCLES     = SERVO_PERIOD_US * CLK_MHZ;
	localparam int STEP_DIV_COARSE  = 16;
	localparam int STEP_DIV_FINE    = 2;
	// ----------------------------------------------------------------
	// Move type encodings
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		MT_IDLE     = 5'h00, MT_REL     = 5'h01, MT_ABS      = 5'h02, MT_HELICAL = 5'h03,
		MT_CIRC     = 5'h04, MT_MODIFY  = 5'h05, MT_FORWARD  = 5'h0A, MT_REVERSE = 5'h0B,
		MT_DATUM    = 5'h0C, MT_CAM     = 5'h0D, MT_FORWARD_JOG_INPUT_SELECT  = 5'h0E, MT_REV_JOG = 5'h0F,
		MT_CAMBOX   = 5'h14, MT_CONNECT = 5'h15, MT_LINKED   = 5'h16
	} amsu_move_t;
endpackage

// ### src/amsu_step_if.sv
// Interface: step pulse divider request and output
`timescale 1ns/1ps
interface amsu_step_if;
	logic        fine;
	logic        alt_gen;
	logic [31:0] rate;
	logic        step;
	modport ctrl (output fine, output alt_gen, output rate, input step);
	modport gen  (input fine, input alt_gen, input rate, output step);
endinterface

// ### src/amsu_step_gen.sv
// Stepper pulse generator with selectable output divider
`timescale 1ns/1ps
module amsu_step_gen (
	input  wire logic   MCLK,
	input  wire logic   RST,
	amsu_step_if.gen    sif
);
	logic [31:0] acc_reg;
	logic [3:0]  div_reg;
	logic [3:0]  div_max;
	logic        tick;
	logic        step_reg;
	logic [32:0] sum;

	assign sum  = {1'b0, acc_reg} + {1'b0, sif.rate};
	assign tick = sum[32];
	// Divide by 16 unless fine mode on the classic generator
	assign div_max = (sif.fine && !sif.alt_gen) ? 4'(amsu_pkg::STEP_DIV_FINE - 1)
	                                            : 4'(amsu_pkg::STEP_DIV_COARSE - 1);
	// ----------------------------------------------------------------
	// Phase accumulator
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			acc_reg <= 32'h00000000;
		end else begin
			acc_reg <= sum[31:0];
		end
	end
	// ----------------------------------------------------------------
	// Output divider
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			div_reg  <= 4'h0;
			step_reg <= 1'b0;
		end else if (tick) begin
			if (div_reg >= div_max) begin
				div_reg  <= 4'h0;
				step_reg <= ~step_reg;
			end else begin
				div_reg <= div_reg + 4'h1;
			end
		end
	end
	assign sif.step = step_reg;
endmodule

// ### src/amsu_top.sv
// Axis motion status unit: move buffer, jog, registration, position, speed and clamp
// Summary of operation
// - Jog input low runs axis at slow speed
// - Report followed axis number during linked moves
// - Primary mark cleared on arm, set on event
// - Z mark cleared on arm, set on latch
// - Merge loads buffered move without stopping
// - Merge needs loaded move, same group, compatible
// - Multi-axis merge uses base axis enable only
// - Step divider 16 normally, 2 in fine
// - Alternative generator always divides by 16
// - Position zeroed at software reset unless resolver fitted
// - Speed from position change per servo period
// - Move type encoding of current move
// - Idle needs current, next, pending all zero
// - Loaded move active on next servo cycle
// - Next type same code, cleared by cancel
// - Offset shifts position, then returns to zero
// - Offset applied at next servo period
// - Windowed registration ignores marks before window
// - Output clamp limits DAC magnitude
// - Clamp applies to direct and servo output
// - Fast jog uses normal speed; -1 unassigned
`timescale 1ns/1ps
module amsu_top #(
	parameter int SERVO_CYCLES = amsu_pkg::SERVO_CYCLES,
	parameter bit ALT_GEN      = 1'b0
) (
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [31:0] INPUTS_N,
	input  wire logic [31:0] ENC_DELTA,
	input  wire logic        REG_EVENT,
	input  wire logic        Z_EVENT,
	input  wire logic [15:0] SERVO_LOOP_OUT,
	output logic [15:0]      DAC_OUT,
	output logic             STEP_OUT,
	output logic [31:0]      SPEED_DEMAND
);
	// ----------------------------------------------------------------
	// Bus decode and registers
	// ----------------------------------------------------------------
	logic        wr;
	logic        rd;
	logic        addr_ok;
	logic [7:0]  ctl_reg;
	logic [31:0] jog_sel_reg;
	logic [31:0] slow_jog_speed_reg;
	logic [31:0] axis_speed_reg;
	logic [31:0] position_offset_reg;
	logic        offset_pend_reg;
	logic [31:0] measured_position_reg;
	logic [31:0] prev_pos_reg;
	logic [31:0] measured_speed_reg;
	logic [31:0] captured_position_reg;
	logic [31:0] z_captured_position_reg;
	logic        registration_flag_reg;
	logic        z_registration_flag_reg;
	logic [31:0] window_open_position_reg;
	logic [15:0] output_clamp_reg;
	logic [15:0] dac_cmd_reg;
	logic [31:0] servo_cnt_reg;
	logic        servo_tick;
	logic [4:0]  current_move_type_reg;
	logic [4:0]  next_move_type_reg;
	logic [4:0]  cur_group_reg;
	logic [4:0]  next_group_reg;
	logic        next_base_reg;
	logic [3:0]  next_link_reg;
	logic [3:0]  linked_axis_number_reg;
	logic        pending_move_reg;
	logic        move_done;
	logic        merge_ok;
	logic        idle;
	logic        arm;
	logic        cancel;
	logic        swrst;
	logic [15:0] dac_next;

	assign wr = PSEL && PENABLE && PWRITE;
	assign rd = PSEL && !PWRITE;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !addr_ok;
	assign arm = wr && (PADDR == amsu_pkg::OFF_CONTROL) && PWDATA[amsu_pkg::CTL_ARM];
	assign cancel = wr && (PADDR == amsu_pkg::OFF_CONTROL) && PWDATA[amsu_pkg::CTL_CANCEL];
	assign swrst = wr && (PADDR == amsu_pkg::OFF_CONTROL) && PWDATA[amsu_pkg::CTL_SWRST];

	always_comb begin
		addr_ok = 1'b1;
		if (PADDR[1:0] != 2'b00) begin
			addr_ok = 1'b0;
		end else if (PADDR > amsu_pkg::OFF_SERVO_PERIOD) begin
			addr_ok = 1'b0;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ctl_reg                  <= 8'h00;
			jog_sel_reg              <= amsu_pkg::RST_JOG_SELECT;
			slow_jog_speed_reg       <= 32'h00000000;
			axis_speed_reg           <= 32'h00000000;
			window_open_position_reg <= 32'h00000000;
			output_clamp_reg         <= amsu_pkg::RST_OUT_CLAMP;
			dac_cmd_reg              <= 16'h0000;
		end else if (wr) begin
			if (PADDR == amsu_pkg::OFF_CONTROL) begin
				ctl_reg <= {1'b0, PWDATA[6], 2'b00, PWDATA[3:0]};
			end else if (PADDR == amsu_pkg::OFF_JOG_SELECT) begin
				jog_sel_reg <= PWDATA;
			end else if (PADDR == amsu_pkg::OFF_SLOW_JOG) begin
				slow_jog_speed_reg <= PWDATA;
			end else if (PADDR == amsu_pkg::OFF_AXIS_SPEED) begin
				axis_speed_reg <= PWDATA;
			end else if (PADDR == amsu_pkg::OFF_WINDOW_OPEN) begin
				window_open_position_reg <= PWDATA;
			end else if (PADDR == amsu_pkg::OFF_OUT_CLAMP) begin
				output_clamp_reg <= PWDATA[15:0];
			end else if (PADDR == amsu_pkg::OFF_DAC_CMD) begin
				dac_cmd_reg <= PWDATA[15:0];
			end
		end
	end
	// ----------------------------------------------------------------
	// Servo period timer
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			servo_cnt_reg <= 32'h00000000;
		end else if (servo_tick) begin
			servo_cnt_reg <= 32'h00000000;
		end else begin
			servo_cnt_reg <= servo_cnt_reg + 32'h00000001;
		end
	end
	assign servo_tick = (servo_cnt_reg == 32'(SERVO_CYCLES - 1));
	// ----------------------------------------------------------------
	// Move buffer
	// ----------------------------------------------------------------
	function automatic logic is_linked(input logic [4:0] t);
		is_linked = (t == amsu_pkg::MT_CAMBOX) || (t == amsu_pkg::MT_CONNECT) ||
		            (t == amsu_pkg::MT_LINKED);
	endfunction
	assign move_done = INPUTS_N[31] == 1'b0;
	// Merge: loaded, same group, same family, base axis enable only
	assign merge_ok = ctl_reg[amsu_pkg::CTL_MERGE] && next_base_reg && pending_move_reg &&
	                  (next_group_reg == cur_group_reg) &&
	                  (is_linked(next_move_type_reg) == is_linked(current_move_type_reg));
	// Idle only when nothing current, next or pending
	assign idle = (current_move_type_reg == 5'h00) && (next_move_type_reg == 5'h00) &&
	              !pending_move_reg;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			next_move_type_reg <= 5'h00;
			next_group_reg     <= 5'h00;
			next_base_reg      <= 1'b0;
			next_link_reg      <= 4'h0;
			pending_move_reg   <= 1'b0;
		end else if (wr && (PADDR == amsu_pkg::OFF_MOVE_CMD) && !pending_move_reg) begin
			next_move_type_reg <= PWDATA[4:0];
			next_group_reg     <= PWDATA[amsu_pkg::MCMD_GROUP +: 5];
			next_base_reg      <= PWDATA[amsu_pkg::MCMD_BASE];
			next_link_reg      <= PWDATA[amsu_pkg::MCMD_LINK +: 4];
			pending_move_reg   <= PWDATA[4:0] != 5'h00;
		end else if (cancel || (servo_tick && pending_move_reg &&
		             (current_move_type_reg == 5'h00 || (move_done && merge_ok)))) begin
			next_move_type_reg <= 5'h00;
			pending_move_reg   <= 1'b0;
		end
	end

	// Buffered move goes active only at the servo tick after loading
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			current_move_type_reg  <= 5'h00;
			cur_group_reg          <= 5'h00;
			linked_axis_number_reg <= 4'h0;
		end else if (servo_tick) begin
			if (pending_move_reg && (current_move_type_reg == 5'h00 ||
			    (move_done && merge_ok))) begin
				current_move_type_reg <= next_move_type_reg;
				cur_group_reg         <= next_group_reg;
				linked_axis_number_reg <= next_link_reg;
			end else if (move_done) begin
				current_move_type_reg <= 5'h00;
			end
		end
	end
	// ----------------------------------------------------------------
	// Jog speed selection
	// ----------------------------------------------------------------
	function automatic logic in_active(input logic [5:0] sel, input logic [31:0] pins);
		in_active = (sel != amsu_pkg::JSEL_NONE) && !pins[sel[4:0]];
	endfunction
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			SPEED_DEMAND <= 32'h00000000;
		end else if (in_active(jog_sel_reg[amsu_pkg::JSEL_FWD +: 6], INPUTS_N) ||
		             in_active(jog_sel_reg[amsu_pkg::JSEL_REV +: 6], INPUTS_N)) begin
			if (in_active(jog_sel_reg[amsu_pkg::JSEL_FAST +: 6], INPUTS_N)) begin
				SPEED_DEMAND <= axis_speed_reg;
			end else begin
				SPEED_DEMAND <= slow_jog_speed_reg;
			end
		end else begin
			SPEED_DEMAND <= axis_speed_reg;
		end
	end
	// ----------------------------------------------------------------
	// Measured position, offset and speed
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			position_offset_reg <= 32'h00000000;
			offset_pend_reg     <= 1'b0;
		end else if (wr && (PADDR == amsu_pkg::OFF_OFFSET)) begin
			position_offset_reg <= PWDATA;
			offset_pend_reg     <= 1'b1;
		end else if (servo_tick && offset_pend_reg) begin
			position_offset_reg <= 32'h00000000;
			offset_pend_reg     <= 1'b0;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			measured_position_reg <= 32'h00000000;
		end else if (swrst && !ctl_reg[amsu_pkg::CTL_RESOLV]) begin
			measured_position_reg <= 32'h00000000;
		end else if (wr && (PADDR == amsu_pkg::OFF_MEAS_POS)) begin
			measured_position_reg <= PWDATA;
		end else if (servo_tick && offset_pend_reg) begin
			measured_position_reg <= measured_position_reg + ENC_DELTA + position_offset_reg;
		end else begin
			measured_position_reg <= measured_position_reg + ENC_DELTA;
		end
	end

	// Speed is position change over one servo period, scaled per second
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			prev_pos_reg       <= 32'h00000000;
			measured_speed_reg <= 32'h00000000;
		end else if (servo_tick) begin
			prev_pos_reg       <= measured_position_reg;
			measured_speed_reg <= 32'((measured_position_reg - prev_pos_reg) *
			                          (1000000 / amsu_pkg::SERVO_PERIOD_US));
		end
	end
	// ----------------------------------------------------------------
	// Registration capture
	// ----------------------------------------------------------------
	logic win_ok;
	assign win_ok = !ctl_reg[amsu_pkg::CTL_WINDOW] ||
	                ($signed(measured_position_reg) >= $signed(window_open_position_reg));
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			registration_flag_reg <= 1'b0;
			captured_position_reg <= 32'h00000000;
		end else if (REG_EVENT && win_ok && (!registration_flag_reg || arm)) begin
			registration_flag_reg <= 1'b1;
			captured_position_reg <= measured_position_reg;
		end else if (arm) begin
			registration_flag_reg <= 1'b0;
		end
	end
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			z_registration_flag_reg <= 1'b0;
			z_captured_position_reg <= 32'h00000000;
		end else if (Z_EVENT && (!z_registration_flag_reg || arm)) begin
			z_registration_flag_reg <= 1'b1;
			z_captured_position_reg <= measured_position_reg;
		end else if (arm) begin
			z_registration_flag_reg <= 1'b0;
		end
	end
	// ----------------------------------------------------------------
	// Output clamp
	// ----------------------------------------------------------------
	always_comb begin
		dac_next = ctl_reg[amsu_pkg::CTL_SERVO] ? SERVO_LOOP_OUT : dac_cmd_reg;
		if ($signed(dac_next) > $signed({1'b0, output_clamp_reg})) begin
			dac_next = output_clamp_reg;
		end else if ($signed(dac_next) < -$signed({1'b0, output_clamp_reg})) begin
			dac_next = 16'(-$signed({1'b0, output_clamp_reg}));
		end
	end
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			DAC_OUT <= 16'h0000;
		end else begin
			DAC_OUT <= dac_next;
		end
	end
	// ----------------------------------------------------------------
	// Step generator
	// ----------------------------------------------------------------
	amsu_step_if sif ();
	assign sif.fine    = ctl_reg[amsu_pkg::CTL_FINE];
	assign sif.alt_gen = ALT_GEN;
	assign sif.rate    = SPEED_DEMAND;
	amsu_step_gen u_step (
		.MCLK (MCLK),
		.RST  (RST),
		.sif  (sif)
	);
	assign STEP_OUT = sif.step;
	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			PRDATA <= 32'h00000000;
		end else if (rd && !PENABLE) begin
			if (PADDR == amsu_pkg::OFF_CONTROL) begin
				PRDATA <= {24'h000000, ctl_reg};
			end else if (PADDR == amsu_pkg::OFF_JOG_SELECT) begin
				PRDATA <= jog_sel_reg;
			end else if (PADDR == amsu_pkg::OFF_SLOW_JOG) begin
				PRDATA <= slow_jog_speed_reg;
			end else if (PADDR == amsu_pkg::OFF_AXIS_SPEED) begin
				PRDATA <= axis_speed_reg;
			end else if (PADDR == amsu_pkg::OFF_MOVE_STATUS) begin
				PRDATA <= {8'h00, linked_axis_number_reg, 3'h0, pending_move_reg,
				           3'h0, next_move_type_reg, 3'h0, current_move_type_reg};
			end else if (PADDR == amsu_pkg::OFF_OFFSET) begin
				PRDATA <= position_offset_reg;
			end else if (PADDR == amsu_pkg::OFF_MEAS_POS) begin
				PRDATA <= measured_position_reg;
			end else if (PADDR == amsu_pkg::OFF_MEAS_SPEED) begin
				PRDATA <= measured_speed_reg;
			end else if (PADDR == amsu_pkg::OFF_REG_POS) begin
				PRDATA <= captured_position_reg;
			end else if (PADDR == amsu_pkg::OFF_Z_POS) begin
				PRDATA <= z_captured_position_reg;
			end else if (PADDR == amsu_pkg::OFF_WINDOW_OPEN) begin
				PRDATA <= window_open_position_reg;
			end else if (PADDR == amsu_pkg::OFF_OUT_CLAMP) begin
				PRDATA <= {16'h0000, output_clamp_reg};
			end else if (PADDR == amsu_pkg::OFF_DAC_CMD) begin
				PRDATA <= {16'h0000, dac_cmd_reg};
			end else if (PADDR == amsu_pkg::OFF_RUN_STATUS) begin
				PRDATA <= {28'h0000000, idle, offset_pend_reg,
				           z_registration_flag_reg, registration_flag_reg};
			end else begin
				PRDATA <= 32'h00000000;
			end
		end
	end
endmodule

// ### tb/amsu_drive_model.sv
// Partner: encoder, registration sensors and servo loop facing the unit
`timescale 1ns/1ps
module amsu_drive_model (
	input  wire logic        fire_reg,
	input  wire logic        fire_z,
	input  wire logic        done,
	input  wire logic [31:0] jog_n,
	input  wire logic [15:0] loop_val,
	output logic [31:0]      INPUTS_N,
	output logic [31:0]      ENC_DELTA,
	output logic             REG_EVENT,
	output logic             Z_EVENT,
	output logic [15:0]      SERVO_LOOP_OUT
);
	// ----
	// Sensor and drive levels
	// ----
	assign INPUTS_N       = {~done, jog_n[30:0]};
	assign ENC_DELTA      = 32'h0;
	assign REG_EVENT      = fire_reg;
	assign Z_EVENT        = fire_z;
	assign SERVO_LOOP_OUT = loop_val;
endmodule

// ### tb/amsu_top_sva.sv
// Checker: bus and output properties of the axis motion status unit
`timescale 1ns/1ps
module amsu_top_sva (
	input wire logic        MCLK,
	input wire logic        RST,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic [15:0] DAC_OUT,
	input wire logic        STEP_OUT
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);
	wire bad_addr = (PADDR > 8'h3C) || (PADDR[1:0] != 2'h0);
	sequence s_access; PSEL && PENABLE; endsequence
	sequence s_rd_setup; PSEL && !PENABLE && !PWRITE; endsequence
	a_ready_high: assert property (PREADY) else $error("ready low");
	a_err_bad: assert property (s_access ##0 bad_addr |-> PSLVERR) else $error("no error");
	a_err_good: assert property (s_access ##0 !bad_addr |-> !PSLVERR) else $error("false error");
	a_err_idle: assert property (!PSEL |-> !PSLVERR) else $error("error when idle");
	a_read_reject: assert property (s_rd_setup ##0 bad_addr |=> PRDATA == 32'h0)
		else $error("unmapped read data");
	a_rdata_hold: assert property (!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
		else $error("read data moved");
	a_dac_sym: assert property (DAC_OUT != 16'h8000) else $error("clamp wrapped");
	a_reset_clear: assert property ($fell(RST) |-> DAC_OUT == 16'h0 && !STEP_OUT)
		else $error("outputs not cleared");
endmodule
bind amsu_top amsu_top_sva u_sva (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.DAC_OUT(DAC_OUT), .STEP_OUT(STEP_OUT));

// ### tb/testbench.sv
// Testbench: register-level tests of the axis motion status unit
`timescale 1ns/1ps
module testbench;
	localparam logic [7:0] ST = amsu_pkg::OFF_MOVE_STATUS, RS = amsu_pkg::OFF_RUN_STATUS,
		OF = amsu_pkg::OFF_OFFSET, MP = amsu_pkg::OFF_MEAS_POS, CT = amsu_pkg::OFF_CONTROL;
	localparam logic [31:0] M = 32'hFFFFFFFF;
	logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        fire_reg = 1'b0, fire_z = 1'b0, done = 1'b0, err, pready, pslverr, reg_ev, z_ev;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, jog_n = 32'hFFFFFFFF, prdata, q, pos, enc, inp, speed;
	logic [15:0] loop_val = 16'h0, dac, servo;
	int          bad_count = 0, samples_checked = 0;
	int          n_step, n_exp;
	logic        step, step_q;
	logic [4:0]  codes [14] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h0A, 5'h0B, 5'h0C,
		5'h0D, 5'h0E, 5'h0F, 5'h14, 5'h15, 5'h16};
	always #5 mclk = ~mclk;
	amsu_drive_model u_far (.fire_reg(fire_reg), .fire_z(fire_z), .done(done), .jog_n(jog_n),
		.loop_val(loop_val), .INPUTS_N(inp), .ENC_DELTA(enc), .REG_EVENT(reg_ev),
		.Z_EVENT(z_ev), .SERVO_LOOP_OUT(servo));
	amsu_top #(.SERVO_CYCLES(40)) u_dut (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .INPUTS_N(inp), .ENC_DELTA(enc), .REG_EVENT(reg_ev), .Z_EVENT(z_ev),
		.SERVO_LOOP_OUT(servo), .DAC_OUT(dac), .STEP_OUT(step), .SPEED_DEMAND(speed));
	// ----
	// Tasks
	// ----
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			bad_count++;
			test_done();
		end
	endtask
	task automatic rc(input string s, input logic [7:0] a, input logic [31:0] m, e);
		apb(1'b0, a, 32'h0);
		check(s, q & m, e);
	endtask
	task automatic wait_tick();
		int n;
		n = 0;
		do begin
			apb(1'b0, OF, 32'h0);
			n++;
		end while (q !== 32'h0 && n < 40);
		if (n >= 40) begin
			bad_count++;
			test_done();
		end
	endtask
	task automatic sync();
		apb(1'b1, OF, 32'h1);
		wait_tick();
		pos = pos + 32'h1;
	endtask
	task automatic tick();
		apb(1'b1, OF, 32'h1);
		rc("offset", OF, M, 32'h1);
		rc("pos early", MP, M, pos);
		wait_tick();
		pos = pos + 32'h1;
		rc("pos shifted", MP, M, pos);
	endtask
	// ----
	// Main sequence
	// ----
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		rc("jog select", amsu_pkg::OFF_JOG_SELECT, M, 32'h003F3F3F);
		rc("clamp", amsu_pkg::OFF_OUT_CLAMP, M, 32'h00007FFF);
		rc("position", MP, M, 32'h0);
		rc("idle", RS, 32'hF, 32'h8);
		rc("unmapped", 8'h40, M, 32'h0);
		check("unmapped err", {31'h0, err}, 32'h1);
		pos = 32'h0;
		sync();
		$display("test reset done");
		foreach (codes[i]) begin
			apb(1'b1, amsu_pkg::OFF_MOVE_CMD, {8'h00, codes[i][3:0], 15'h0, codes[i]});
			rc("next type", ST, 32'h1F1F, {19'h0, codes[i], 8'h00});
			tick();
			rc("current type", ST, 32'h1F, {27'h0, codes[i]});
			rc("busy", RS, 32'h8, 32'h0);
			if (codes[i] >= 5'h14) rc("link", ST, 32'hF00000, {8'h0, codes[i][3:0], 20'h0});
			done <= 1'b1;
			tick();
			done <= 1'b0;
			rc("ended", ST, 32'h1F1F, 32'h0);
			rc("idle again", RS, 32'h8, 32'h8);
		end
		$display("test move types done");
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, CT, {31'h0, k != 1});
			apb(1'b1, amsu_pkg::OFF_MOVE_CMD, 32'h10001);
			tick();
			apb(1'b1, amsu_pkg::OFF_MOVE_CMD, (k == 2) ? 32'h10016 : 32'h10002);
			done <= 1'b1;
			tick();
			rc("merged", ST, 32'h1F, (k == 0) ? 32'h2 : 32'h0);
			apb(1'b1, CT, 32'h20);
			rc("cancelled", ST, 32'h1F00, 32'h0);
			tick();
			done <= 1'b0;
			rc("flushed", ST, 32'h1F1F, 32'h0);
		end
		$display("test merge done");
		fire_reg <= 1'b1;
		fire_z <= 1'b1;
		@(posedge mclk);
		fire_reg <= 1'b0;
		fire_z <= 1'b0;
		rc("marks", RS, 32'h3, 32'h3);
		rc("mark pos", amsu_pkg::OFF_REG_POS, M, pos);
		rc("z pos", amsu_pkg::OFF_Z_POS, M, pos);
		apb(1'b1, CT, 32'h10);
		rc("armed", RS, 32'h3, 32'h0);
		apb(1'b1, amsu_pkg::OFF_WINDOW_OPEN, pos + 32'h64);
		apb(1'b1, CT, 32'h18);
		fire_reg <= 1'b1;
		@(posedge mclk);
		fire_reg <= 1'b0;
		rc("windowed", RS, 32'h1, 32'h0);
		$display("test registration done");
		apb(1'b1, amsu_pkg::OFF_OUT_CLAMP, 32'h64);
		for (int k = 0; k < 4; k++) begin
			loop_val <= (k == 2) ? 16'hEC78 : 16'h1388;
			apb(1'b1, CT, {29'h0, k > 1, 2'h0});
			apb(1'b1, amsu_pkg::OFF_DAC_CMD, (k == 0) ? 32'hFFFFFF00 : 32'h32);
			repeat (4) @(posedge mclk);
			#1 check("dac", {16'h0, dac}, (k == 1) ? 32'h32 : (k == 3) ? 32'h64 : 32'hFF9C);
		end
		$display("test clamp done");
		sync();
		apb(1'b1, amsu_pkg::OFF_SLOW_JOG, 32'h11);
		apb(1'b1, amsu_pkg::OFF_AXIS_SPEED, 32'h22);
		apb(1'b1, amsu_pkg::OFF_JOG_SELECT, 32'h00043F03);
		jog_n <= 32'hFFFFFFF7;
		tick();
		#1 check("slow jog", speed, 32'h11);
		jog_n <= 32'hFFFFFFE7;
		tick();
		#1 check("fast jog", speed, 32'h22);
		rc("speed", amsu_pkg::OFF_MEAS_SPEED, M, 32'h3E8);
		$display("test jog done");
		jog_n <= M;
		apb(1'b1, amsu_pkg::OFF_AXIS_SPEED, 32'h80000000);
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, CT, {30'h0, k == 1, 1'b0});
			n_exp = 64 / (2 * ((k == 1) ? amsu_pkg::STEP_DIV_FINE :
				amsu_pkg::STEP_DIV_COARSE));
			n_step = 0;
			repeat (40) @(posedge mclk);
			#1 step_q = step;
			repeat (64) begin
				@(posedge mclk);
				#1 n_step += int'(step !== step_q);
				step_q = step;
			end
			check("step toggles", n_step, n_exp);
		end
		$display("test step done");
		test_done();
	end
endmodule
